/* hw/dbs_pkg.sv */
// Constants and types for the dual buck set-point configuration block
package dbs_pkg;
  localparam int unsigned CODE_W      = 7;
  localparam int unsigned LOW_W       = 6;
  localparam int unsigned MV_W        = 12;
  localparam int unsigned NUM_CHAN    = 2;
  localparam int unsigned NUM_MODE    = 3;
  // Arrangement field codes
  localparam logic [1:0]  ARR_SINGLE0 = 2'h0;
  localparam logic [1:0]  ARR_SINGLE1 = 2'h1;
  localparam logic [1:0]  ARR_RSVD    = 2'h2;
  localparam logic [1:0]  ARR_INDEP   = 2'h3;
  // Operating mode codes
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_STANDBY = 2'h1;
  localparam logic [1:0]  MODE_SLEEP   = 2'h2;
  // Channel index
  localparam logic        CHAN_A      = 1'b0;
  localparam logic        CHAN_B      = 1'b1;
  // Voltage steps in millivolts
  localparam logic [MV_W-1:0] LOW_BASE_MV  = 12'h190; // 400 mV
  localparam logic [MV_W-1:0] LOW_STEP_MV  = 12'h019; // 25 mV
  localparam logic [MV_W-1:0] HIGH_BASE_MV = 12'h320; // 800 mV
  localparam logic [MV_W-1:0] HIGH_STEP_MV = 12'h032; // 50 mV
  // Reset values and strap capture delay
  localparam logic [LOW_W-1:0] CODE_RST   = 6'h00;
  localparam logic [1:0]       LOAD_DELAY = 2'h2;
  typedef enum logic [1:0] {ARR_E_SINGLE, ARR_E_RESERVED, ARR_E_INDEPENDENT} dbs_arr_e;
endpackage : dbs_pkg

/* hw/dbs_setpoint_cfg.sv */
// Arrangement decode, set-point storage and mode selection for two buck channels
// Notes on behaviour
// RULE_01: Arrangement field 00/01 means single phase, 11 independent, 10 reserved.
// RULE_02: In single phase host programs channel B identical to channel A.
// RULE_03: Independent arrangement: each channel driven only by its own settings.
// RULE_04: Range bit of normal code is read-only, set from one-time strap.
// RULE_05: Range 0: output is 400 mV plus 25 mV times low code.
// RULE_06: Range 1: output is 800 mV plus 50 mV times low code.
// RULE_07: Each channel holds separate six-bit codes for normal, standby, sleep.
// RULE_08: Initial range bit copied into standby and sleep codes too.
// RULE_09: Host should use high range for 2.0-3.3 V, low for 0.4-1.975 V.
// RULE_10: Host must not program outputs of 0.6 V or below.
// RULE_11: Each channel applies the code of the operating mode in effect.
// RULE_12: Single phase: combined output follows channel A code and mode only.
module dbs_setpoint_cfg (
  // Clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         nrst_i,
  // One-time-programmed straps
  input  wire logic [1:0]                   phase_arrangement_select_i,
  input  wire logic [dbs_pkg::NUM_CHAN-1:0] otp_range_i,
  // Host set-point write port
  input  wire logic                         wr_en_i,
  input  wire logic                         wr_chan_i,
  input  wire logic [1:0]                   wr_mode_i,
  input  wire logic [dbs_pkg::LOW_W-1:0]    wr_code_i,
  // Host read-back port
  input  wire logic                         rd_chan_i,
  input  wire logic [1:0]                   rd_mode_i,
  output logic      [dbs_pkg::CODE_W-1:0]   rd_code_o,
  // Operating mode per channel
  input  wire logic [1:0]                   mode_a_i,
  input  wire logic [1:0]                   mode_b_i,
  // Status
  output logic                              cfg_loaded_o,
  output logic                              single_phase_o,
  output logic                              arr_reserved_o,
  // Applied set points
  output logic      [dbs_pkg::CODE_W-1:0]   chan_a_code_o,
  output logic      [dbs_pkg::CODE_W-1:0]   chan_b_code_o,
  output logic      [dbs_pkg::MV_W-1:0]     chan_a_mv_o,
  output logic      [dbs_pkg::MV_W-1:0]     chan_b_mv_o
);
  import dbs_pkg::*;

  function automatic logic [MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] code);
    logic [MV_W-1:0] low;
    low = {{(MV_W-LOW_W){1'b0}}, code[LOW_W-1:0]};
    if (code[CODE_W-1]) begin
      code_to_mv = HIGH_BASE_MV + MV_W'(low * HIGH_STEP_MV); // RULE_06
    end else begin
      code_to_mv = LOW_BASE_MV + MV_W'(low * LOW_STEP_MV); // RULE_05
    end
  endfunction : code_to_mv

  function automatic logic [1:0] mode_idx(input logic [1:0] mode);
    mode_idx = (mode == MODE_STANDBY || mode == MODE_SLEEP) ? mode : MODE_NORMAL;
  endfunction : mode_idx

  // Strap synchronisers
  logic [1:0]          arr_s1_q, arr_s2_q;
  logic [NUM_CHAN-1:0] rng_s1_q, rng_s2_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arr_s1_q <= 2'h0;
      arr_s2_q <= 2'h0;
      rng_s1_q <= '0;
      rng_s2_q <= '0;
    end else begin
      arr_s1_q <= phase_arrangement_select_i;
      arr_s2_q <= arr_s1_q;
      rng_s1_q <= otp_range_i;
      rng_s2_q <= rng_s1_q;
    end
  end

  // One-shot capture after reset release
  logic [1:0] load_cnt_q;
  logic       loaded_q;
  logic       load_now;
  assign load_now = !loaded_q && (load_cnt_q == LOAD_DELAY);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_cnt_q <= 2'h0;
      loaded_q   <= 1'b0;
    end else begin
      if (!loaded_q && load_cnt_q != LOAD_DELAY) begin
        load_cnt_q <= load_cnt_q + 2'h1;
      end
      if (load_now) begin
        loaded_q <= 1'b1;
      end
    end
  end

  // Arrangement decode
  dbs_arr_e arr_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arr_q <= ARR_E_SINGLE;
    end else if (load_now) begin
      unique case (arr_s2_q)
        ARR_SINGLE0, ARR_SINGLE1: arr_q <= ARR_E_SINGLE; // RULE_01
        ARR_INDEP:                arr_q <= ARR_E_INDEPENDENT; // RULE_01
        ARR_RSVD:                 arr_q <= ARR_E_RESERVED; // RULE_01
      endcase
    end
  end

  // Range bits, one per channel, shared by all three modes
  logic [NUM_CHAN-1:0] range_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      range_q <= '0;
    end else if (load_now) begin
      range_q <= rng_s2_q; // RULE_04 RULE_08
    end
  end

  // Low code storage, indexed by channel and mode
  logic [LOW_W-1:0] code_q [NUM_CHAN][NUM_MODE];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        for (int m = 0; m < NUM_MODE; m++) begin
          code_q[c][m] <= CODE_RST;
        end
      end
    end else if (wr_en_i && wr_mode_i != 2'h3) begin
      code_q[wr_chan_i][wr_mode_i] <= wr_code_i; // RULE_07 RULE_03
    end
  end

  // Applied codes
  logic                single;
  logic [1:0]          ma, mb;
  logic [CODE_W-1:0]   sel_a, sel_b;
  logic [CODE_W-1:0]   app_a_q, app_b_q;
  logic [MV_W-1:0]     mv_a_q, mv_b_q;
  assign single = (arr_q != ARR_E_INDEPENDENT);
  assign ma     = mode_idx(mode_a_i);
  assign mb     = mode_idx(mode_b_i);
  assign sel_a  = {range_q[CHAN_A], code_q[CHAN_A][ma]}; // RULE_11
  assign sel_b  = single ? sel_a : {range_q[CHAN_B], code_q[CHAN_B][mb]}; // RULE_12 RULE_03
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      app_a_q <= '0;
      app_b_q <= '0;
      mv_a_q  <= LOW_BASE_MV;
      mv_b_q  <= LOW_BASE_MV;
    end else begin
      app_a_q <= sel_a;
      app_b_q <= sel_b;
      mv_a_q  <= code_to_mv(sel_a); // RULE_05 RULE_06
      mv_b_q  <= code_to_mv(sel_b);
    end
  end

  // Read-back
  logic [CODE_W-1:0] rd_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_q <= '0;
    end else begin
      rd_q <= {range_q[rd_chan_i], code_q[rd_chan_i][mode_idx(rd_mode_i)]}; // RULE_04
    end
  end

  assign rd_code_o      = rd_q;
  assign cfg_loaded_o   = loaded_q;
  assign single_phase_o = single;
  assign arr_reserved_o = (arr_q == ARR_E_RESERVED);
  assign chan_a_code_o  = app_a_q;
  assign chan_b_code_o  = app_b_q;
  assign chan_a_mv_o    = mv_a_q;
  assign chan_b_mv_o    = mv_b_q;

  // Checks
  chk_arr_decode: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_01
    load_now |=> (single_phase_o == ($past(arr_s2_q) != ARR_INDEP))
                 && (arr_reserved_o == ($past(arr_s2_q) == ARR_RSVD)))
    else $error("arrangement decode wrong");
  chk_single_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_12
    single_phase_o |=> chan_b_code_o == $past(sel_a))
    else $error("channel B does not follow A in single phase");
  chk_indep_own: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_03
    !single_phase_o |=> chan_b_code_o == {range_q[CHAN_B], $past(code_q[CHAN_B][mb])})
    else $error("channel B not from own settings");
  chk_low_range: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_05
    !chan_a_code_o[6] |-> chan_a_mv_o == 12'h190 + 12'h019 * {6'h00, chan_a_code_o[5:0]})
    else $error("low range voltage wrong");
  chk_high_range: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_06
    chan_b_code_o[6] |-> chan_b_mv_o == 12'h320 + 12'h032 * {6'h00, chan_b_code_o[5:0]})
    else $error("high range voltage wrong");
  chk_range_fixed: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_04
    loaded_q |=> $stable(range_q))
    else $error("range bit changed after load");
  chk_mode_apply: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_11
    (wr_en_i && !wr_chan_i && wr_mode_i == MODE_STANDBY && mode_a_i == MODE_STANDBY) ##1
    (mode_a_i == MODE_STANDBY && !wr_en_i) |=> chan_a_code_o[5:0] == $past(wr_code_i, 2))
    else $error("standby code not applied");
  chk_range_copy: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_08
    loaded_q && (mode_a_i == MODE_SLEEP) |=> chan_a_code_o[6] == range_q[CHAN_A])
    else $error("sleep code range differs from normal");
  chk_code_store: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_07
    wr_en_i && wr_mode_i != 2'h3 |=> code_q[$past(wr_chan_i)][$past(wr_mode_i)] == $past(wr_code_i))
    else $error("set-point write lost");
  chk_chan_a_own: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_11
    1'b1 |=> chan_a_code_o == $past({range_q[CHAN_A], code_q[CHAN_A][ma]}))
    else $error("channel A code not from its own mode slot");
  chk_range_b_copy: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_08
    loaded_q && !single && (mode_b_i == MODE_STANDBY) |=> chan_b_code_o[6] == range_q[CHAN_B])
    else $error("standby code range differs from normal");
  chk_rd_range: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_04
    1'b1 |=> rd_code_o[6] == $past(range_q[rd_chan_i]))
    else $error("read-back range bit not the strapped value");
  chk_load_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_04
    cfg_loaded_o |=> cfg_loaded_o)
    else $error("strap capture flag dropped");
  chk_arr_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE_01
    loaded_q |=> $stable(arr_q))
    else $error("arrangement changed after capture");
endmodule : dbs_setpoint_cfg

/* dv/dbs_host_model.sv */
// Host model issuing one-cycle set-point writes
module dbs_host_model (
  // Clock
  input  wire logic       mclk_i,
  // Write port toward the block
  output logic            wr_en_o,
  output logic            wr_chan_o,
  output logic [1:0]      wr_mode_o,
  output logic [5:0]      wr_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wr_en_o = 1'b0;
  initial wr_chan_o = 1'b0;
  initial wr_mode_o = 2'h0;
  initial wr_code_o = 6'h00;
  // Called just after an edge, held through the next one
  task automatic put(input logic ch, input logic [1:0] md, input logic [5:0] cd);
    wr_en_o = 1'b1;
    wr_chan_o = ch;
    wr_mode_o = md;
    wr_code_o = cd;
    @(posedge mclk_i);
    #1;
  endtask : put
  task automatic idle();
    wr_en_o = 1'b0;
  endtask : idle
  // Same code into both channels in single phase
  task automatic pair(input logic [1:0] md, input logic [5:0] cd);
    put(1'b0, md, cd);
    put(1'b1, md, cd);
  endtask : pair
endmodule : dbs_host_model

/* dv/dbs_setpoint_cfg_tb_top.sv */
// Self-checking bench for the dual buck set-point block
module dbs_setpoint_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dbs_pkg::*;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [1:0]  arr_sel = 2'h0;
  logic [1:0]  rng = 2'h0;
  logic [1:0]  mode_a = 2'h0;
  logic [1:0]  mode_b = 2'h0;
  logic        rd_chan = 1'b0;
  logic [1:0]  rd_mode = 2'h0;
  logic        wr_en, wr_chan, single, rsvd, loaded;
  logic [1:0]  wr_mode;
  logic [5:0]  wr_code;
  logic [6:0]  rd_code, a_code, b_code;
  logic [11:0] a_mv, b_mv;
  int          failures = 0;
  int          tests_run = 0;
  always #50 mclk_i = ~mclk_i;
  dbs_host_model host_u (.mclk_i(mclk_i), .wr_en_o(wr_en), .wr_chan_o(wr_chan), .wr_mode_o(wr_mode),
    .wr_code_o(wr_code));
  dbs_setpoint_cfg dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .phase_arrangement_select_i(arr_sel),
    .otp_range_i(rng), .wr_en_i(wr_en), .wr_chan_i(wr_chan), .wr_mode_i(wr_mode), .wr_code_i(wr_code),
    .rd_chan_i(rd_chan), .rd_mode_i(rd_mode), .rd_code_o(rd_code), .mode_a_i(mode_a), .mode_b_i(mode_b),
    .cfg_loaded_o(loaded), .single_phase_o(single), .arr_reserved_o(rsvd), .chan_a_code_o(a_code),
    .chan_b_code_o(b_code), .chan_a_mv_o(a_mv), .chan_b_mv_o(b_mv));
  function automatic logic [11:0] mv(input logic r, input logic [5:0] c);
    return r ? HIGH_BASE_MV + 12'(c) * HIGH_STEP_MV : LOW_BASE_MV + 12'(c) * LOW_STEP_MV;
  endfunction : mv
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chan(input logic [6:0] code, input logic [11:0] v, input logic r, input logic [5:0] c);
    chk({5'h00, code}, {5'h00, r, c});
    chk(v, mv(r, c));
  endtask : chan
  task automatic restart(input logic [1:0] a, input logic [1:0] r);
    nrst_i = 1'b0;
    arr_sel = a;
    rng = r;
    repeat (20) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : restart
  task automatic test_arrangement();
    for (int a = 0; a < 4; a++) begin
      restart(2'(a), 2'h0);
      chk({11'h000, single}, {11'h000, a != 3});
      chk({11'h000, rsvd}, {11'h000, a == 2});
      chk({11'h000, loaded}, 12'h001);
      chan(a_code, a_mv, 1'b0, CODE_RST);
    end
    $display("test_arrangement done");
  endtask : test_arrangement
  task automatic test_independent();
    logic [5:0] ca [3] = '{6'h09, 6'h14, 6'h3F};
    logic [5:0] cb [3] = '{6'h18, 6'h32, 6'h20};
    restart(ARR_INDEP, 2'h2);
    for (int m = 0; m < 3; m++) host_u.put(CHAN_A, 2'(m), ca[m]);
    for (int m = 0; m < 3; m++) host_u.put(CHAN_B, 2'(m), cb[m]);
    host_u.put(CHAN_A, 2'h3, 6'h10);
    host_u.idle();
    for (int m = 0; m < 3; m++) begin
      mode_a = 2'(m);
      mode_b = 2'(2 - m);
      rd_chan = CHAN_B;
      rd_mode = 2'(m);
      @(posedge mclk_i);
      #1;
      chan(a_code, a_mv, 1'b0, ca[m]);
      chan(b_code, b_mv, 1'b1, cb[2 - m]);
      chk({5'h00, rd_code}, {5'h00, 1'b1, cb[m]});
    end
    mode_a = MODE_STANDBY;
    host_u.put(CHAN_A, MODE_STANDBY, 6'h2A);
    host_u.idle();
    repeat (2) @(posedge mclk_i);
    #1;
    chan(a_code, a_mv, 1'b0, 6'h2A);
    $display("test_independent done");
  endtask : test_independent
  task automatic test_single();
    restart(ARR_SINGLE1, 2'h1);
    host_u.pair(MODE_NORMAL, 6'h1E);
    host_u.pair(MODE_STANDBY, 6'h28);
    host_u.idle();
    mode_a = MODE_STANDBY;
    mode_b = MODE_NORMAL;
    @(posedge mclk_i);
    #1;
    chan(a_code, a_mv, 1'b1, 6'h28);
    chan(b_code, b_mv, 1'b1, 6'h28);
    $display("test_single done");
  endtask : test_single
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    test_arrangement();
    test_independent();
    test_single();
    test_done();
  end
  // Run needs about 160 cycles
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule : dbs_setpoint_cfg_tb_top
